/* File: nfq_bus_cycle.sv */
// nfq_bus_cycle: one asynchronous flash read or write pin cycle.
// assumes the flash samples on its strobe edges; inputs synchronous to pclk.
`timescale 1ns/1ps
module nfq_bus_cycle
  import nfq_pkg::*;
#(
  parameter int AW = NFQ_AW,
  parameter int DW = NFQ_DW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic is_write,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic done,
  output logic [DW-1:0] rdata_q,
  output logic [AW-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [DW-1:0] data_pins_o,
  output logic data_pins_oe,
  input wire logic [DW-1:0] data_pins_i
);
  nfq_cy_t st_q;
  logic [7:0] cnt_q;
  logic wr_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wd_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= NFQ_CY_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      addr_q <= '0;
      wd_q <= '0;
      rdata_q <= '0;
    end else begin
      case (st_q)
        NFQ_CY_IDLE: begin
          if (start) begin
            st_q <= NFQ_CY_SETUP;
            wr_q <= is_write;
            addr_q <= addr;
            wd_q <= wdata;
            cnt_q <= 8'(NFQ_SU_CYC);
          end
        end
        NFQ_CY_SETUP: begin
          // address stable before the strobe falls
          if (cnt_q == 8'h01) begin
            st_q <= NFQ_CY_STROBE;
            cnt_q <= 8'(NFQ_WP_CYC);
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        NFQ_CY_STROBE: begin
          if (cnt_q == 8'h01) begin
            st_q <= NFQ_CY_HOLD;
            if (!wr_q) begin
              rdata_q <= data_pins_i;
            end
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: st_q <= NFQ_CY_IDLE;
      endcase
    end
  end

  assign done = (st_q == NFQ_CY_HOLD);
  assign flash_addr = addr_q;
  // chip select spans the strobe so the we edges set latch points
  assign flash_ce_n = !(st_q == NFQ_CY_SETUP || st_q == NFQ_CY_STROBE
    || st_q == NFQ_CY_HOLD); // RL8
  assign flash_we_n = !(wr_q && st_q == NFQ_CY_STROBE); // RL7 RL8
  assign flash_oe_n = !(!wr_q && st_q == NFQ_CY_STROBE); // RL7
  assign data_pins_o = wd_q;
  assign data_pins_oe = wr_q && st_q != NFQ_CY_IDLE; // RL7
endmodule

/* File: nfq_ctrl.sv */
// nfq_ctrl: apb-driven host controller for a parallel nor flash.
// assumes apb master on pclk; flash pins sampled synchronously to pclk.
`timescale 1ns/1ps
module nfq_ctrl
  import nfq_pkg::*;
#(
  parameter int AW = NFQ_AW,
  parameter int DW = NFQ_DW,
  parameter int POLL_MAX = NFQ_POLL_MAX
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [AW-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_reset_n,
  output logic [DW-1:0] data_pins_o,
  output logic data_pins_oe,
  input wire logic [DW-1:0] data_pins_i
);
  typedef enum logic [4:0] {
    NFQ_S_IDLE, NFQ_S_U1, NFQ_S_U2, NFQ_S_CMD, NFQ_S_DATA,
    NFQ_S_POLL1, NFQ_S_POLL2, NFQ_S_READ, NFQ_S_Q0, NFQ_S_Q1,
    NFQ_S_Q2, NFQ_S_Q3, NFQ_S_Q4, NFQ_S_Q5, NFQ_S_EXIT, NFQ_S_RST
  } nfq_st_t;

  nfq_st_t st_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wdata_q;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] id_q [6];
  logic skip_q;
  logic busy_q;
  logic err_q;
  logic done_q;
  logic [31:0] poll_q;
  logic [DW-1:0] prev_q;
  logic [2:0] op_start;
  logic go;
  logic cy_start;
  logic cy_write;
  logic [AW-1:0] cy_addr;
  logic [DW-1:0] cy_wdata;
  logic cy_done;
  logic [DW-1:0] cy_rdata;
  logic wr_en;
  logic [31:0] rd_d;
  logic [2:0] op_start_q;
  logic cy_busy;

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign op_start = pwdata[NFQ_C_OP_LSB +: NFQ_C_OP_W];
  assign go = wr_en && paddr == NFQ_R_CTRL && op_start != NFQ_OP_NONE
    && !busy_q;

  always_comb begin
    pslverr = 1'b0;
    rd_d = 32'h00000000;
    if (paddr == NFQ_R_CTRL) begin
      rd_d = {27'h0000000, skip_q, 4'h0};
    end else if (paddr == NFQ_R_ADDR) begin
      rd_d = 32'(addr_q);
    end else if (paddr == NFQ_R_WDATA) begin
      rd_d = {16'h0000, wdata_q};
    end else if (paddr == NFQ_R_RDATA) begin
      rd_d = {16'h0000, rdata_q};
    end else if (paddr == NFQ_R_STATUS) begin
      rd_d = {29'h00000000, err_q, done_q, busy_q};
    end else if (paddr == NFQ_R_ID01) begin
      rd_d = {id_q[1], id_q[0]};
    end else if (paddr == NFQ_R_ID23) begin
      rd_d = {id_q[3], id_q[2]};
    end else if (paddr == NFQ_R_IDEF) begin
      rd_d = {id_q[5], id_q[4]};
    end else begin
      pslverr = psel && penable;
    end
  end
  assign prdata = (psel && penable && !pwrite) ? rd_d : 32'h00000000;

  // software registers; writes to addr and data ignored while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= '0;
      wdata_q <= '0;
      skip_q <= 1'b0;
    end else if (wr_en && !busy_q) begin
      if (paddr == NFQ_R_CTRL) begin
        skip_q <= pwdata[NFQ_C_SKIP];
      end else if (paddr == NFQ_R_ADDR) begin
        addr_q <= pwdata[AW-1:0];
      end else if (paddr == NFQ_R_WDATA) begin
        wdata_q <= pwdata[DW-1:0];
      end
    end
  end

  // sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= NFQ_S_IDLE;
      busy_q <= 1'b0;
      err_q <= 1'b0;
      done_q <= 1'b0;
      poll_q <= 32'h00000000;
      prev_q <= '0;
    end else begin
      case (st_q)
        NFQ_S_IDLE: begin
          if (go) begin
            busy_q <= 1'b1;
            done_q <= 1'b0;
            err_q <= 1'b0;
            if (op_start == NFQ_OP_READ) begin
              st_q <= NFQ_S_READ;
            end else if (op_start == NFQ_OP_PROG) begin
              // skip bit of this same write drops the unlock pair
              st_q <= pwdata[NFQ_C_SKIP] ? NFQ_S_CMD
                : NFQ_S_U1; // RL9 RL19 RL20
            end else if (op_start == NFQ_OP_QUERY) begin
              st_q <= NFQ_S_U1; // RL22
            end else begin
              st_q <= NFQ_S_RST; // RL16
            end
          end
        end
        NFQ_S_RST: begin
          // reset pulse held one cycle, then flash is in read mode
          st_q <= NFQ_S_IDLE;
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        NFQ_S_POLL1: begin
          if (cy_done) begin
            prev_q <= cy_rdata;
            poll_q <= 32'h00000000;
            st_q <= NFQ_S_POLL2;
          end
        end
        NFQ_S_POLL2: begin
          if (cy_done) begin
            prev_q <= cy_rdata;
            poll_q <= poll_q + 32'h00000001;
            // toggle bit stops toggling when the flash is back in read
            if (cy_rdata[NFQ_TOGGLE_BIT] == prev_q[NFQ_TOGGLE_BIT]) begin
              st_q <= NFQ_S_IDLE; // RL10 RL11
              busy_q <= 1'b0;
              done_q <= 1'b1;
              // a 0 in flash cannot become 1 again
              err_q <= (cy_rdata & ~wdata_q) != '0 ||
                (cy_rdata != wdata_q); // RL12 RL13
            end else if (poll_q == 32'(POLL_MAX)) begin
              st_q <= NFQ_S_IDLE;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              err_q <= 1'b1;
            end
          end
        end
        default: begin
          if (cy_done) begin
            case (st_q)
              NFQ_S_U1: st_q <= NFQ_S_U2;
              NFQ_S_U2: st_q <= NFQ_S_CMD;
              NFQ_S_CMD: st_q <= (op_start_q == NFQ_OP_PROG) ?
                NFQ_S_DATA : NFQ_S_Q0;
              NFQ_S_DATA: st_q <= NFQ_S_POLL1; // RL14 RL15
              NFQ_S_Q0: st_q <= NFQ_S_Q1; // RL6
              NFQ_S_Q1: st_q <= NFQ_S_Q2;
              NFQ_S_Q2: st_q <= NFQ_S_Q3;
              NFQ_S_Q3: st_q <= NFQ_S_Q4;
              NFQ_S_Q4: st_q <= NFQ_S_Q5;
              NFQ_S_Q5: st_q <= NFQ_S_EXIT;
              default: begin
                st_q <= NFQ_S_IDLE; // RL2 RL23
                busy_q <= 1'b0;
                done_q <= 1'b1;
              end
            endcase
          end
        end
      endcase
    end
  end

  // operation kind held across the sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_start_q <= NFQ_OP_NONE;
    end else if (go) begin
      op_start_q <= op_start;
    end
  end

  // read results
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
      for (int i = 0; i < 6; i++) begin
        id_q[i] <= '0;
      end
    end else if (cy_done) begin
      case (st_q)
        NFQ_S_READ: rdata_q <= cy_rdata;
        NFQ_S_POLL2: rdata_q <= cy_rdata;
        NFQ_S_Q0: id_q[0] <= cy_rdata; // RL3
        NFQ_S_Q1: id_q[1] <= cy_rdata; // RL3
        NFQ_S_Q2: id_q[2] <= cy_rdata; // RL4
        NFQ_S_Q3: id_q[3] <= cy_rdata; // RL5
        NFQ_S_Q4: id_q[4] <= cy_rdata; // RL3
        NFQ_S_Q5: id_q[5] <= cy_rdata; // RL3
        default: ;
      endcase
    end
  end

  // pin cycle request per state
  always_comb begin
    cy_write = 1'b0;
    cy_addr = addr_q;
    cy_wdata = '0;
    cy_start = 1'b0;
    case (st_q)
      NFQ_S_U1: begin
        cy_write = 1'b1;
        cy_addr = NFQ_UNLOCK1_ADDR; // RL1 RL21
        cy_wdata = NFQ_UNLOCK1_DATA;
      end
      NFQ_S_U2: begin
        cy_write = 1'b1;
        cy_addr = NFQ_UNLOCK2_ADDR; // RL1 RL21
        cy_wdata = NFQ_UNLOCK2_DATA;
      end
      NFQ_S_CMD: begin
        cy_write = 1'b1;
        cy_addr = NFQ_UNLOCK1_ADDR;
        cy_wdata = (op_start_q == NFQ_OP_PROG) ? NFQ_CMD_PROG
          : NFQ_CMD_QUERY; // RL1 RL21
      end
      NFQ_S_DATA: begin
        cy_write = 1'b1;
        cy_addr = addr_q; // RL17 RL18
        cy_wdata = wdata_q;
      end
      NFQ_S_Q0: cy_addr = NFQ_Q_MAKER;
      NFQ_S_Q1: cy_addr = NFQ_Q_DEV1;
      // lock word read at offset 02 of the sector base held in the address register
      NFQ_S_Q2: cy_addr = addr_q | NFQ_Q_LOCK; // RL4
      NFQ_S_Q3: cy_addr = NFQ_Q_FACT;
      NFQ_S_Q4: cy_addr = NFQ_Q_DEV2;
      NFQ_S_Q5: cy_addr = NFQ_Q_DEV3;
      NFQ_S_EXIT: begin
        cy_write = 1'b1;
        cy_addr = NFQ_Q_MAKER;
        cy_wdata = NFQ_CMD_EXIT; // RL2
      end
      default: ;
    endcase
    if (st_q != NFQ_S_IDLE && st_q != NFQ_S_RST && !cy_done && !cy_busy) begin
      cy_start = 1'b1;
    end
  end

  assign cy_busy = !flash_ce_n;
  assign flash_reset_n = !(st_q == NFQ_S_RST); // RL16

  nfq_bus_cycle #(
    .AW(AW),
    .DW(DW)
  ) u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .start(cy_start),
    .is_write(cy_write),
    .addr(cy_addr),
    .wdata(cy_wdata),
    .done(cy_done),
    .rdata_q(cy_rdata),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n),
    .data_pins_o(data_pins_o),
    .data_pins_oe(data_pins_oe),
    .data_pins_i(data_pins_i)
  );
endmodule

/* File: nfq_ctrl_chk.sv */
// nfq_ctrl_chk: port-level checks on the flash command controller.
// assumes it is bound to nfq_ctrl; one clock domain on pclk.
`timescale 1ns/1ps
module nfq_ctrl_chk
  import nfq_pkg::*;
#(
  parameter int AW = NFQ_AW,
  parameter int DW = NFQ_DW,
  parameter int POLL_MAX = NFQ_POLL_MAX
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [AW-1:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_reset_n,
  input wire logic [DW-1:0] data_pins_o,
  input wire logic data_pins_oe,
  input wire logic [DW-1:0] data_pins_i
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_wr_pins;
    !flash_we_n |-> !flash_ce_n && flash_oe_n && data_pins_oe;
  endproperty
  a_wr_pins: assert property (p_wr_pins)
    else $error("write strobe without select or data drive");
  property p_rd_pins;
    !flash_oe_n |-> flash_we_n && !data_pins_oe && !flash_ce_n;
  endproperty
  a_rd_pins: assert property (p_rd_pins)
    else $error("read strobe overlaps a write or data drive");
  property p_we_width;
    $fell(flash_we_n) |-> !flash_we_n [*5] ##1 flash_we_n;
  endproperty
  a_we_width: assert property (p_we_width)
    else $error("write strobe not five cycles");
  property p_oe_width;
    $fell(flash_oe_n) |-> !flash_oe_n [*5] ##1 flash_oe_n;
  endproperty
  a_oe_width: assert property (p_oe_width)
    else $error("read strobe not five cycles");
  property p_addr_hold;
    !flash_we_n && $past(!flash_we_n) |->
      $stable(flash_addr) && $stable(data_pins_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address or data moved under write strobe");
  property p_ce_setup;
    $fell(flash_we_n) |-> $past(!flash_ce_n);
  endproperty
  a_ce_setup: assert property (p_ce_setup)
    else $error("select not set up before write strobe");
  property p_ce_hold;
    $rose(flash_we_n) |-> !flash_ce_n && data_pins_oe;
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("select or data dropped with write strobe");
  property p_rst_pulse;
    $fell(flash_reset_n) |=> flash_reset_n;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("flash reset pulse not one cycle");
  property p_slverr;
    psel && penable && paddr > 8'h1c |-> pslverr && pready;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("unmapped access without error response");
endmodule
bind nfq_ctrl nfq_ctrl_chk #(.AW(AW), .DW(DW), .POLL_MAX(POLL_MAX))
  nfq_ctrl_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
  .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
  .flash_reset_n(flash_reset_n), .data_pins_o(data_pins_o),
  .data_pins_oe(data_pins_oe), .data_pins_i(data_pins_i));

/* File: nfq_ctrl_tb_top.sv */
// nfq_ctrl_tb_top: self-checking bench for the flash command controller.
// assumes nfq_ctrl with POLL_MAX 50 and the behavioural flash model.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module nfq_ctrl_tb_top;
  import nfq_pkg::*;
  localparam logic [15:0] MAKER = 16'h00a5; // arbitrary value
  localparam logic [15:0] DEV1 = 16'h3c11; // arbitrary value
  localparam logic [15:0] DEV2 = 16'h3c22; // arbitrary value
  localparam logic [15:0] DEV3 = 16'h3c33; // arbitrary value
  localparam logic [15:0] FACT = 16'h0089;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic skip_en = 1'b0;
  logic [15:0] busy_reads = 16'h0001;
  logic [31:0] prdata;
  logic pready, pslverr, ce_n, we_n, oe_n, rst_n, dq_oe, query_q;
  logic [23:0] faddr;
  logic [15:0] dq_o, fl_dq;
  wire [15:0] dq = dq_oe ? dq_o : fl_dq;
  int n_errors = 0;
  int checks = 0;
  int n_wr, n_rst;
  nfq_ctrl #(.POLL_MAX(50)) nfq_ctrl_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(faddr), .flash_ce_n(ce_n), .flash_we_n(we_n),
    .flash_oe_n(oe_n), .flash_reset_n(rst_n), .data_pins_o(dq_o),
    .data_pins_oe(dq_oe), .data_pins_i(dq));
  nfq_flash_model #(.MAKER(MAKER), .DEV1(DEV1), .DEV2(DEV2), .DEV3(DEV3),
    .FACT(FACT)) nfq_flash_model_i (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .reset_n(rst_n), .addr(faddr), .dq_in(dq), .skip_en(skip_en),
    .busy_reads(busy_reads), .dq_out(fl_dq), .query_q(query_q),
    .n_wr(n_wr), .n_rst(n_rst));
  initial forever #4 pclk = ~pclk;
  task automatic test_done;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_errors++;
      test_done();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  // start an operation and poll the busy flag under a bound
  task automatic run(input logic [31:0] ctrl);
    logic [31:0] s;
    int n;
    n = 0;
    wr(NFQ_R_CTRL, ctrl);
    do begin
      rd(NFQ_R_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      n_errors++;
      test_done();
    end
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    apb(1'b0, NFQ_R_STATUS, 32'h0, r, e);
    `CHK(r[2:0], 3'h0)
    `CHK(e, 1'b0)
    apb(1'b0, 8'h40, 32'h0, r, e);
    `CHK(e, 1'b1)
  endtask
  task automatic t_query(input logic [23:0] base, input logic [15:0] lock);
    logic [31:0] r;
    int w0;
    wr(NFQ_R_ADDR, {8'h00, base});
    w0 = n_wr;
    run({29'h0, NFQ_OP_QUERY});
    `CHK(n_wr - w0, 4)
    rd(NFQ_R_ID01, r);
    `CHK(r, {DEV1, MAKER})
    rd(NFQ_R_ID23, r);
    `CHK(r, {FACT, lock})
    rd(NFQ_R_IDEF, r);
    `CHK(r, {DEV3, DEV2})
    `CHK(query_q, 1'b0)
  endtask
  task automatic t_prog(input logic [23:0] a, input logic [15:0] d,
    input logic sk, input logic [15:0] nb, input logic [15:0] exp,
    input logic er, input int nw);
    logic [31:0] r;
    int w0;
    skip_en <= sk;
    busy_reads <= nb;
    wr(NFQ_R_ADDR, {8'h00, a});
    wr(NFQ_R_WDATA, {16'h0, d});
    w0 = n_wr;
    run({27'h0, sk, 1'b0, NFQ_OP_PROG});
    `CHK(n_wr - w0, nw)
    rd(NFQ_R_STATUS, r);
    `CHK(r[2:0], {er, 2'b10})
    run({29'h0, NFQ_OP_READ});
    rd(NFQ_R_RDATA, r);
    `CHK(r[15:0], exp)
  endtask
  task automatic t_abort;
    logic [31:0] r;
    int r0;
    int w0;
    skip_en <= 1'b0;
    busy_reads <= 16'd200;
    r0 = n_rst;
    wr(NFQ_R_ADDR, 32'h0000_0200);
    wr(NFQ_R_WDATA, 32'h0000_5a5a);
    w0 = n_wr;
    wr(NFQ_R_CTRL, {29'h0, NFQ_OP_PROG});
    // a query request while busy is refused
    run({29'h0, NFQ_OP_QUERY});
    `CHK(n_wr - w0, 4)
    `CHK(query_q, 1'b0)
    rd(NFQ_R_STATUS, r);
    `CHK(r[2], 1'b1)
    run({29'h0, 3'h4});
    `CHK(n_rst - r0, 1)
    run({29'h0, NFQ_OP_READ});
    rd(NFQ_R_RDATA, r);
    `CHK(r[15:0], 16'h5a5a)
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_query(24'h000000, 16'h0000);
    t_query(24'h010000, 16'h0001);
    t_prog(24'h000100, 16'h00f0, 1'b0, 16'd1, 16'h00f0, 1'b0, 4);
    t_prog(24'h000100, 16'h0030, 1'b1, 16'd4, 16'h0030, 1'b0, 2);
    t_prog(24'h7f0155, 16'h1234, 1'b0, 16'd2, 16'h1234, 1'b0, 4);
    t_prog(24'h000100, 16'h0f0f, 1'b0, 16'd1, 16'h0000, 1'b1, 4);
    t_abort();
    test_done();
  end
endmodule

/* File: nfq_flash_model.sv */
// nfq_flash_model: behavioural 16-bit nor flash, acts on pin edges.
// assumes the controller's strobes; busy lasts busy_reads status reads.
`timescale 1ns/1ps
module nfq_flash_model #(
  parameter logic [15:0] MAKER = 16'h0000,
  parameter logic [15:0] DEV1 = 16'h0000,
  parameter logic [15:0] DEV2 = 16'h0000,
  parameter logic [15:0] DEV3 = 16'h0000,
  parameter logic [15:0] FACT = 16'h0000
) (
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic reset_n,
  input wire logic [23:0] addr,
  input wire logic [15:0] dq_in,
  input wire logic skip_en,
  input wire logic [15:0] busy_reads,
  output logic [15:0] dq_out,
  output logic query_q,
  output int n_wr,
  output int n_rst
);
  logic [15:0] mem [int];
  logic [15:0] out_q = 16'h0000;
  logic [15:0] pd = 16'hffff;
  logic [23:0] a_q = 24'h000000;
  logic busy = 1'b0;
  logic tog = 1'b0;
  int step = 0;
  int left = 0;
  wire wr = !we_n && !ce_n;
  initial begin
    query_q = 1'b0;
    n_wr = 0;
    n_rst = 0;
  end
  // released pins show the inverse of the last value
  assign dq_out = (!ce_n && !oe_n) ? out_q : ~out_q;
  always @(posedge wr) a_q = addr;
  always @(negedge wr) begin
    n_wr++;
    if (busy) begin
    end else if (step == 3) begin
      // program data may equal the exit code; it is data here
      pd = mem.exists(int'(a_q)) ? mem[int'(a_q)] : 16'hffff;
      pd = pd & dq_in;
      mem[int'(a_q)] = pd;
      busy = 1'b1;
      left = int'(busy_reads);
      step = 0;
    end else if (dq_in == 16'h00f0) begin
      query_q = 1'b0;
      step = 0;
    end else if (step == 0 && skip_en && dq_in == 16'h00a0)
      step = 3;
    else if (step == 0 && a_q[11:0] == 12'h555 && dq_in == 16'h00aa)
      step = 1;
    else if (step == 1 && a_q[11:0] == 12'h2aa && dq_in == 16'h0055)
      step = 2;
    else if (step == 2 && a_q[11:0] == 12'h555 && dq_in == 16'h0090) begin
      query_q = 1'b1;
      step = 0;
    end else if (step == 2 && a_q[11:0] == 12'h555 && dq_in == 16'h00a0)
      step = 3;
    else
      step = 0;
  end
  always @(negedge oe_n) begin
    if (!ce_n && busy) begin
      tog = ~tog;
      out_q = {8'h00, ~pd[7], tog, 6'h00};
      left--;
      if (left <= 0)
        busy = 1'b0;
    end else if (!ce_n && query_q) begin
      case (addr[7:0])
        8'h00: out_q = MAKER;
        8'h01: out_q = DEV1;
        8'h02: out_q = {15'h0000, addr[16]};
        8'h03: out_q = FACT;
        8'h0e: out_q = DEV2;
        8'h0f: out_q = DEV3;
        default: out_q = 16'h0000;
      endcase
    end else if (!ce_n)
      out_q = mem.exists(int'(addr)) ? mem[int'(addr)] : 16'hffff;
  end
  always @(negedge reset_n) begin
    busy = 1'b0;
    query_q = 1'b0;
    step = 0;
    n_rst++;
  end
endmodule

/* File: nfq_pkg.sv */
// nfq_pkg: constants for the flash command controller (host side).
// assumes a 16-bit parallel nor flash on asynchronous pins, apb registers.
// Notes on behaviour
// RL1: id-query entry is aa at 555, 55 at 2aa, 90 at 555.
// RL2: id-query exit is one f0 write at any address.
// RL3: query reads give maker at 00, device words at 01, 0e, 0f.
// RL4: query read at sector base plus 02 gives lock state, 01 or 00.
// RL5: query read at 03 gives factory-lock bit 7 and guard sector bits.
// RL6: any number of query reads are allowed until exit is written.
// RL7: host writes with chip select and write strobe low, output enable high.
// RL8: flash latches address on last falling edge, data on first rising.
// RL9: unlock-skip lets program commands go without the two unlock cycles.
// RL10: after programming ends the flash returns to array read.
// RL11: during programming the data pins show progress status bits.
// RL12: programming never turns a stored 0 into a 1.
// RL13: only erase turns stored 0 bits into 1.
// RL14: while busy the flash ignores all commands except suspend.
// RL15: while programming, query functions are unavailable.
// RL16: hardware reset aborts programming; host reissues the sequence after. The controller pulses reset only when not busy and reissues nothing.
// RL17: single-word programs may go to any address in any order.
// RL18: the same word may be programmed repeatedly without erase.
// RL19: single-word program takes four write cycles, data 8 or 16 bits.
// RL20: buffered programming is preferred where supported; advice only.
// RL21: program cycles are aa at 555, 55 at 2aa, a0 at 555, data.
// RL22: host must not enter id-query while the flash is busy.
// RL23: exit returns the flash to array read or erase-suspend read.
// RL24: a mismatched sequence write abandons the sequence.
package nfq_pkg;
  localparam int NFQ_AW = 24;
  localparam int NFQ_DW = 16;
  // flash command words and word addresses
  localparam logic [NFQ_AW-1:0] NFQ_UNLOCK1_ADDR = 24'h000555;
  localparam logic [NFQ_AW-1:0] NFQ_UNLOCK2_ADDR = 24'h0002aa;
  localparam logic [NFQ_DW-1:0] NFQ_UNLOCK1_DATA = 16'h00aa;
  localparam logic [NFQ_DW-1:0] NFQ_UNLOCK2_DATA = 16'h0055;
  localparam logic [NFQ_DW-1:0] NFQ_CMD_QUERY = 16'h0090;
  localparam logic [NFQ_DW-1:0] NFQ_CMD_EXIT = 16'h00f0;
  localparam logic [NFQ_DW-1:0] NFQ_CMD_PROG = 16'h00a0;
  // query offsets
  localparam logic [NFQ_AW-1:0] NFQ_Q_MAKER = 24'h000000;
  localparam logic [NFQ_AW-1:0] NFQ_Q_DEV1 = 24'h000001;
  localparam logic [NFQ_AW-1:0] NFQ_Q_LOCK = 24'h000002;
  localparam logic [NFQ_AW-1:0] NFQ_Q_FACT = 24'h000003;
  localparam logic [NFQ_AW-1:0] NFQ_Q_DEV2 = 24'h00000e;
  localparam logic [NFQ_AW-1:0] NFQ_Q_DEV3 = 24'h00000f;
  localparam int NFQ_FACT_BIT = 7;
  localparam int NFQ_TOGGLE_BIT = 6;
  // apb register byte addresses
  localparam logic [7:0] NFQ_R_CTRL = 8'h00;
  localparam logic [7:0] NFQ_R_ADDR = 8'h04;
  localparam logic [7:0] NFQ_R_WDATA = 8'h08;
  localparam logic [7:0] NFQ_R_RDATA = 8'h0c;
  localparam logic [7:0] NFQ_R_STATUS = 8'h10;
  localparam logic [7:0] NFQ_R_ID01 = 8'h14;
  localparam logic [7:0] NFQ_R_ID23 = 8'h18;
  localparam logic [7:0] NFQ_R_IDEF = 8'h1c;
  // ctrl register fields
  localparam int NFQ_C_OP_LSB = 0;
  localparam int NFQ_C_OP_W = 3;
  localparam int NFQ_C_SKIP = 4;
  // timing, in picoseconds and in derived cycles of pclk
  localparam int NFQ_CLK_PS = 8000;
  localparam int NFQ_T_WP_PS = 35000;
  localparam int NFQ_T_SETUP_PS = 16000;
  localparam int NFQ_WP_CYC = (NFQ_T_WP_PS + NFQ_CLK_PS - 1) / NFQ_CLK_PS;
  localparam int NFQ_SU_CYC =
    (NFQ_T_SETUP_PS + NFQ_CLK_PS - 1) / NFQ_CLK_PS;
  localparam int NFQ_POLL_MAX = 100000;
  localparam logic [2:0] NFQ_OP_NONE = 3'h0;
  localparam logic [2:0] NFQ_OP_READ = 3'h1;
  localparam logic [2:0] NFQ_OP_PROG = 3'h2;
  localparam logic [2:0] NFQ_OP_QUERY = 3'h3;
  typedef enum logic [1:0] {
    NFQ_CY_IDLE,
    NFQ_CY_SETUP,
    NFQ_CY_STROBE,
    NFQ_CY_HOLD
  } nfq_cy_t;
endpackage
